//--- rtl/gpcd_latch_bank.sv
// Data latch bank without reset, written from the register bus
`timescale 1ns/10ps
module gpcd_latch_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] q_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [WIDTH-1:0] latch;
	} gpcd_lb_st_t;

	gpcd_lb_st_t st_ff;
	gpcd_lb_st_t nxt_st;

	// Write whatever the direction is; reset leaves the latches alone
	always_comb begin
		nxt_st = st_ff;
		if (wr_i) begin
			nxt_st.latch = wdata_i; // [RULE_06]
		end
	end

	// No reset on purpose: latch content survives reset
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st; // [RULE_01] [RULE_08]
	end

	assign q_o = st_ff.latch;
endmodule : gpcd_latch_bank

//--- rtl/gpcd_pin_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/10ps
module gpcd_pin_sync #(
	parameter int WIDTH = 14
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} gpcd_ps_st_t;

	gpcd_ps_st_t st_ff;
	gpcd_ps_st_t nxt_st;

	// First stage is read only by the second
	always_comb begin
		nxt_st.meta = d_i;
		nxt_st.sync = st_ff.meta;
	end

	// Pins sampled on the system clock
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st; // [RULE_15]
		end
	end

	assign q_o = st_ff.sync;
endmodule : gpcd_pin_sync

//--- rtl/gpcd_pkg.sv
// Types shared by the port C and D block
package gpcd_pkg;
	// Bus slave phase
	typedef enum logic [0:0] {
		GPCD_IDLE,
		GPCD_DONE
	} gpcd_phase_t;
endpackage : gpcd_pkg

//--- rtl/gpcd_ports.sv
// Port C and port D general-purpose I/O with clock output, Avalon-MM slave
//
// Behaviour
// [RULE_01] Six port C data latches, read/write, untouched by reset.
// [RULE_02] Clock output enable bit 7 of C direction drives clock on pin 2.
// [RULE_03] Clock output overrides pin 2 direction; reset clears the enable.
// [RULE_04] C direction 1 enables output buffer; reset makes all pins inputs.
// [RULE_05] C data read returns latch for outputs, synced pin for inputs.
// [RULE_06] Latches accept writes regardless of direction.
// [RULE_07] Software should write latch before turning a pin to output.
// [RULE_08] Eight port D data latches, direction from matching D direction bit.
// [RULE_09] D direction 1 enables output buffer; reset clears all bits.
// [RULE_10] D data read returns latch for outputs, synced pin for inputs.
// [RULE_11] Converter-selected D pins 6..0 read 0 as input, latch as output.
// [RULE_12] Timer-used D pins ignore direction for drive, still select read; the code reads them as 0 when inputs, not the synced pin.
// [RULE_13] D6 feeds first timer clock, D4 second, when prescaler selects.
// [RULE_14] With clock output on, C bit 2 reads 0 and writes don't reach pin.
// [RULE_15] Writes land at the edge ending the cycle; pins sampled on clock.
//
// Decided for this implementation: the Avalon-MM slave port.
`include "gpcd_regs.svh"
`timescale 1ns/10ps
module gpcd_ports #(
	parameter int CPINS = `GPCD_C_PINS,
	parameter int DPINS = `GPCD_D_PINS
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [CPINS-1:0] pc_pin_i,
	output logic [CPINS-1:0] pc_pin_o,
	output logic [CPINS-1:0] pc_pin_oe_o,
	input wire logic [DPINS-1:0] pd_pin_i,
	output logic [DPINS-1:0] pd_pin_o,
	output logic [DPINS-1:0] pd_pin_oe_o,
	input wire logic [4:0] converter_channel_select_i,
	input wire logic [2:0] first_prescaler_select_i,
	input wire logic [2:0] second_prescaler_select_i,
	output logic first_timer_ext_clock_o,
	output logic second_timer_ext_clock_o
);
	// ****************************************
	// State and wires
	// ****************************************
	typedef struct packed {
		gpcd_pkg::gpcd_phase_t phase;
		logic [7:0] c_dir;
		logic [7:0] d_dir;
		logic [31:0] rdata;
	} gpcd_st_t;

	gpcd_st_t st_ff;
	gpcd_st_t nxt_st;
	logic req;
	logic wr_fire;
	logic wr_c_latch;
	logic wr_d_latch;
	logic [CPINS-1:0] c_latch;
	logic [DPINS-1:0] d_latch;
	logic [CPINS+DPINS-1:0] pins_sync;
	logic [CPINS-1:0] c_sync;
	logic [DPINS-1:0] d_sync;
	logic clk_out_en;
	logic [DPINS-1:0] d_timer_use;
	logic [DPINS-1:0] d_adc_use;
	logic [7:0] c_read;
	logic [7:0] d_read;

	// Converter picks one D pin; channels 8..14 map to pins 0..6
	function automatic logic [7:0] adc_pin_mask(input logic [4:0] ch);
		logic [4:0] idx;
		adc_pin_mask = 8'h00;
		idx = ch - `GPCD_ADC_BASE;
		if (ch >= `GPCD_ADC_BASE && idx < 5'h07) begin
			adc_pin_mask[idx[2:0]] = 1'b1;
		end
	endfunction : adc_pin_mask

	// Per-bit read mux: latch for output, pin or forced 0 for input
	function automatic logic [7:0] read_mux(input logic [7:0] dir, input logic [7:0] lat,
			input logic [7:0] pin, input logic [7:0] zero_in);
		read_mux = (dir & lat) | (~dir & pin & ~zero_in);
	endfunction : read_mux

	// ****************************************
	// Submodules
	// ****************************************
	gpcd_latch_bank #(.WIDTH(CPINS)) u_c_latch (
		.clk_i(clk_i),
		.wr_i(wr_c_latch),
		.wdata_i(avs_writedata_i[CPINS-1:0]),
		.q_o(c_latch)
	);

	gpcd_latch_bank #(.WIDTH(DPINS)) u_d_latch (
		.clk_i(clk_i),
		.wr_i(wr_d_latch),
		.wdata_i(avs_writedata_i[DPINS-1:0]),
		.q_o(d_latch)
	);

	gpcd_pin_sync #(.WIDTH(CPINS+DPINS)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i({pd_pin_i, pc_pin_i}),
		.q_o(pins_sync)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	// One wait cycle; a write lands only at the edge where waitrequest is low
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & (st_ff.phase == gpcd_pkg::GPCD_IDLE);
	assign wr_fire = avs_write_i & (st_ff.phase == gpcd_pkg::GPCD_DONE) & avs_byteenable_i[0];
	assign wr_c_latch = wr_fire & (avs_address_i == `GPCD_IDX_C_LATCH); // [RULE_15]
	assign wr_d_latch = wr_fire & (avs_address_i == `GPCD_IDX_D_LATCH); // [RULE_15]
	assign avs_readdata_o = st_ff.rdata;

	// ****************************************
	// Pin side
	// ****************************************
	assign c_sync = pins_sync[CPINS-1:0];
	assign d_sync = pins_sync[CPINS+DPINS-1:CPINS];
	assign clk_out_en = st_ff.c_dir[`GPCD_CLKOUT_BIT];
	assign d_adc_use = adc_pin_mask(converter_channel_select_i);

	// Timer use of D6 and D4 when prescaler picks the external clock
	always_comb begin
		d_timer_use = '0;
		d_timer_use[`GPCD_TA_PIN] = (first_prescaler_select_i == `GPCD_PS_EXT); // [RULE_13]
		d_timer_use[`GPCD_TB_PIN] = (second_prescaler_select_i == `GPCD_PS_EXT); // [RULE_13]
	end

	assign first_timer_ext_clock_o = d_timer_use[`GPCD_TA_PIN] & d_sync[`GPCD_TA_PIN];
	assign second_timer_ext_clock_o = d_timer_use[`GPCD_TB_PIN] & d_sync[`GPCD_TB_PIN];

	// Port C drive; clock output bypasses pin 2 direction
	always_comb begin
		pc_pin_o = c_latch;
		pc_pin_oe_o = st_ff.c_dir[CPINS-1:0]; // [RULE_04]
		if (clk_out_en) begin
			pc_pin_o[`GPCD_CLKOUT_PIN] = clk_i; // [RULE_02] [RULE_14]
			pc_pin_oe_o[`GPCD_CLKOUT_PIN] = 1'b1; // [RULE_03]
		end
	end

	// Port D drive; converter and timer pins are kept as inputs
	assign pd_pin_o = d_latch;
	assign pd_pin_oe_o = st_ff.d_dir & ~d_timer_use & ~d_adc_use; // [RULE_09] [RULE_12]

	// Read values
	always_comb begin
		c_read = read_mux(st_ff.c_dir, {2'b00, c_latch}, {2'b00, c_sync}, 8'h00); // [RULE_05]
		if (clk_out_en) begin
			c_read[`GPCD_CLKOUT_PIN] = 1'b0; // [RULE_14]
		end
		c_read[7:6] = 2'b00;
		d_read = read_mux(st_ff.d_dir, d_latch, d_sync,
			d_adc_use | d_timer_use); // [RULE_10] [RULE_11] [RULE_12]
	end

	// ****************************************
	// Register state
	// ****************************************
	// Direction writes and the registered read answer
	always_comb begin
		nxt_st = st_ff;
		nxt_st.phase = gpcd_pkg::GPCD_IDLE;
		if (req && st_ff.phase == gpcd_pkg::GPCD_IDLE) begin
			nxt_st.phase = gpcd_pkg::GPCD_DONE;
			nxt_st.rdata = `GPCD_UNMAPPED;
			if (avs_read_i) begin
				case (avs_address_i)
					`GPCD_IDX_C_LATCH: nxt_st.rdata = {24'h000000, c_read};
					`GPCD_IDX_D_LATCH: nxt_st.rdata = {24'h000000, d_read};
					`GPCD_IDX_C_DIR: nxt_st.rdata = {24'h000000, st_ff.c_dir};
					`GPCD_IDX_D_DIR: nxt_st.rdata = {24'h000000, st_ff.d_dir};
					default: nxt_st.rdata = `GPCD_UNMAPPED;
				endcase
			end
		end
		// Direction writes take effect in the accepting cycle only
		if (wr_fire && avs_address_i == `GPCD_IDX_C_DIR) begin
			nxt_st.c_dir = avs_writedata_i[7:0] & `GPCD_C_DIR_WMASK; // [RULE_04]
		end
		if (wr_fire && avs_address_i == `GPCD_IDX_D_DIR) begin
			nxt_st.d_dir = avs_writedata_i[7:0]; // [RULE_09]
		end
	end

	// Reset clears both direction registers and the clock enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff.phase <= gpcd_pkg::GPCD_IDLE;
			st_ff.c_dir <= `GPCD_C_DIR_RST; // [RULE_03] [RULE_04]
			st_ff.d_dir <= `GPCD_D_DIR_RST; // [RULE_09]
			st_ff.rdata <= `GPCD_UNMAPPED;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_clk_out_drive: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_02]
		clk_out_en |-> pc_pin_oe_o[`GPCD_CLKOUT_PIN]) else $error("clock pin not driven");
	chk_c_dir_oe: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_04]
		!clk_out_en |-> pc_pin_oe_o == st_ff.c_dir[CPINS-1:0]) else $error("C enable mismatch");
	chk_c_read_clk: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_14]
		(clk_out_en && avs_read_i && !avs_waitrequest_o && avs_address_i == `GPCD_IDX_C_LATCH)
		|-> !avs_readdata_o[`GPCD_CLKOUT_PIN]) else $error("C bit 2 not zero");
	chk_d_oe_timer: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_12]
		d_timer_use[`GPCD_TA_PIN] |-> !pd_pin_oe_o[`GPCD_TA_PIN]) else $error("timer pin driven");
	chk_d_read_adc: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_11]
		(d_adc_use[0] && !st_ff.d_dir[0]) |-> !d_read[0]) else $error("adc read not zero");
	chk_d_dir_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_09]
		(wr_fire && avs_address_i == `GPCD_IDX_D_DIR) |=> st_ff.d_dir == $past(avs_writedata_i[7:0]))
		else $error("D dir not written");
	chk_wait_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_15]
		$rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait not one cycle");
	chk_d_read_out: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_10]
		st_ff.d_dir[7] |-> d_read[7] == d_latch[7]) else $error("D read not latch");
	cov_clk_out: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(clk_out_en));
	cov_c_write: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_c_latch);
	cov_timer_sel: cover property (@(posedge clk_i) disable iff (!rstn_i) d_timer_use[`GPCD_TB_PIN]);
endmodule : gpcd_ports

//--- rtl/gpcd_regs.svh
// Register offsets, field positions and reset values of the port C and D block
`ifndef GPCD_REGS_SVH
`define GPCD_REGS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define GPCD_IDX_C_LATCH 4'h2
`define GPCD_IDX_D_LATCH 4'h3
`define GPCD_IDX_C_DIR 4'h6
`define GPCD_IDX_D_DIR 4'h7

// ****************************************
// Fields and reset values
// ****************************************
`define GPCD_CLKOUT_BIT 7
`define GPCD_CLKOUT_PIN 2
`define GPCD_C_PINS 6
`define GPCD_D_PINS 8
`define GPCD_C_DIR_RST 8'h00
`define GPCD_D_DIR_RST 8'h00
`define GPCD_C_DIR_WMASK 8'hBF
`define GPCD_TA_PIN 6
`define GPCD_TB_PIN 4
`define GPCD_ADC_BASE 5'h08
`define GPCD_PS_EXT 3'h7
`define GPCD_UNMAPPED 32'h00000000

`endif

//--- tb/gpcd_pin_model.sv
// Pin-side partner: outside drivers resolved against the block's output buffers
`timescale 1ns/10ps
module gpcd_pin_model (
	input wire logic [5:0] c_drv_i,
	input wire logic [5:0] c_oe_i,
	input wire logic [5:0] c_ext_i,
	output logic [5:0] c_pin_o,
	input wire logic [7:0] d_drv_i,
	input wire logic [7:0] d_oe_i,
	input wire logic [7:0] d_ext_i,
	output logic [7:0] d_pin_o
);
	// Block wins where its buffer is on; elsewhere the outside source sets the level
	assign c_pin_o = (c_oe_i & c_drv_i) | (~c_oe_i & c_ext_i);
	assign d_pin_o = (d_oe_i & d_drv_i) | (~d_oe_i & d_ext_i);
endmodule : gpcd_pin_model

//--- tb/testbench.sv
// Self-checking bench for the port C and D block
`include "gpcd_regs.svh"
`timescale 1ns/10ps
module testbench;
	logic clk_i = 0, rstn_i = 0, rd_i = 0, wr_i = 0;
	logic [3:0] addr = 4'h0, be = 4'hF;
	logic [31:0] wdata = 32'h0, rdata;
	logic waitreq;
	logic [5:0] pc_i, pc_o, pc_oe, ext_c = 6'h2A;
	logic [7:0] pd_i, pd_o, pd_oe, ext_d = 8'hC3;
	logic [4:0] chsel = 5'h00;
	logic [2:0] ps1 = 3'h0, ps2 = 3'h0;
	logic tclk1, tclk2;
	int n_errors = 0, compares = 0, cycles = 0;
	gpcd_ports u_gpcd_ports (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
		.avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.pc_pin_i(pc_i), .pc_pin_o(pc_o), .pc_pin_oe_o(pc_oe), .pd_pin_i(pd_i),
		.pd_pin_o(pd_o), .pd_pin_oe_o(pd_oe), .converter_channel_select_i(chsel),
		.first_prescaler_select_i(ps1), .second_prescaler_select_i(ps2),
		.first_timer_ext_clock_o(tclk1), .second_timer_ext_clock_o(tclk2));
	gpcd_pin_model u_gpcd_pin_model (.c_drv_i(pc_o), .c_oe_i(pc_oe), .c_ext_i(ext_c),
		.c_pin_o(pc_i), .d_drv_i(pd_o), .d_oe_i(pd_oe), .d_ext_i(ext_d), .d_pin_o(pd_i));
	// ****************************************
	// Clock, watchdog and shared tasks
	// ****************************************
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Watchdog: a hung handshake must not stall the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	task stop_test;
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request held until the edge at which waitrequest is low
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= {24'h000000, d};
		wr_i <= 1'b1;
		do @(posedge clk_i); while (waitreq !== 1'b0);
		wr_i <= 1'b0;
	endtask : wr
	// Read data taken at the same rising edge that sees waitrequest low
	task rdc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd_i <= 1'b1;
		do @(posedge clk_i); while (waitreq !== 1'b0);
		rd_i <= 1'b0;
		check(rdata, {24'h000000, exp});
	endtask : rdc
	task pins(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : pins
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		pins(3);
		check(32'({pd_oe, 2'b00, pc_oe}), 32'h0);
		rdc(`GPCD_IDX_C_DIR, 8'h00);
		rdc(`GPCD_IDX_D_DIR, 8'h00);
		rdc(`GPCD_IDX_C_LATCH, 8'h2A);
		rdc(`GPCD_IDX_D_LATCH, 8'hC3);
		wr(`GPCD_IDX_C_LATCH, 8'h15);
		rdc(`GPCD_IDX_C_LATCH, 8'h2A);
		wr(`GPCD_IDX_C_DIR, 8'h3F);
		pins(0);
		check(32'(pc_oe), 32'h3F);
		check(32'(pc_o), 32'h15);
		rdc(`GPCD_IDX_C_LATCH, 8'h15);
		// Clock out on: pin 2 carries the clock, its data bit reads 0
		wr(`GPCD_IDX_C_DIR, 8'hFF);
		rdc(`GPCD_IDX_C_DIR, 8'hBF);
		rdc(`GPCD_IDX_C_LATCH, 8'h11);
		@(negedge clk_i) #1 check(32'(pc_o[2]), 32'h0);
		@(posedge clk_i) #1 check(32'(pc_o[2]), 32'h1);
		wr(`GPCD_IDX_C_LATCH, 8'h3F);
		wr(`GPCD_IDX_C_DIR, 8'hBB);
		pins(0);
		check(32'(pc_oe), 32'h3F);
		check(32'(pc_o & 6'h3B), 32'h3B);
		rdc(`GPCD_IDX_C_LATCH, 8'h3B);
		wr(`GPCD_IDX_C_DIR, 8'h00);
		pins(1);
		rdc(`GPCD_IDX_C_LATCH, 8'h2A);
		// Mid-run reset: direction clears, latches survive
		@(posedge clk_i) rstn_i <= 1'b0;
		@(posedge clk_i) rstn_i <= 1'b1;
		rdc(`GPCD_IDX_C_DIR, 8'h00);
		wr(`GPCD_IDX_C_DIR, 8'h3F);
		rdc(`GPCD_IDX_C_LATCH, 8'h3F);
		// Port D plain I/O and a write with its byte lane off
		wr(`GPCD_IDX_D_LATCH, 8'hA5);
		wr(`GPCD_IDX_D_DIR, 8'hFF);
		pins(0);
		check(32'({pd_oe, pd_o}), 32'hFFA5);
		rdc(`GPCD_IDX_D_DIR, 8'hFF);
		be <= 4'h0;
		wr(`GPCD_IDX_D_LATCH, 8'h00);
		be <= 4'hF;
		rdc(`GPCD_IDX_D_LATCH, 8'hA5);
		wr(`GPCD_IDX_D_DIR, 8'h0F);
		pins(1);
		rdc(`GPCD_IDX_D_LATCH, 8'hC5);
		rdc(4'h5, 8'h00);
		// Every converter channel on port D reads 0 while an input
		wr(`GPCD_IDX_D_DIR, 8'h00);
		ext_d <= 8'hFF;
		for (int ch = 0; ch < 7; ch++) begin
			chsel <= 5'(8 + ch);
			pins(3);
			rdc(`GPCD_IDX_D_LATCH, 8'hFF ^ (8'h01 << ch));
		end
		wr(`GPCD_IDX_D_DIR, 8'hFF);
		chsel <= `GPCD_ADC_BASE;
		pins(1);
		check(32'(pd_oe), 32'hFE);
		rdc(`GPCD_IDX_D_LATCH, 8'hA5);
		chsel <= 5'h00;
		// Timer external clocks on D6 and D4
		ps1 <= `GPCD_PS_EXT;
		pins(1);
		check(32'(pd_oe), 32'hBF);
		rdc(`GPCD_IDX_D_LATCH, 8'hA5);
		wr(`GPCD_IDX_D_DIR, 8'h00);
		pins(1);
		rdc(`GPCD_IDX_D_LATCH, 8'hBF);
		check(32'({tclk1, tclk2}), 32'h2);
		ext_d <= 8'hAF;
		pins(3);
		check(32'(tclk1), 32'h0);
		@(posedge clk_i);
		ps2 <= `GPCD_PS_EXT;
		ext_d <= 8'hFF;
		ps1 <= 3'h0;
		pins(3);
		check(32'({tclk1, tclk2}), 32'h1);
		stop_test();
	end
endmodule : testbench
